//--- hdl/alu_status_params.svh
// Constants for the processor status word block.
// Assumes inclusion by bare name from the modules.
`ifndef ALU_STATUS_PARAMS_SVH
`define ALU_STATUS_PARAMS_SVH
`define PSW_FLAG_N_BIT      0
`define PSW_FLAG_C_BIT      1
`define PSW_FLAG_V_BIT      2
`define PSW_FLAG_Z_BIT      3
`define PSW_FLAG_E_BIT      4
`define PSW_MULDIV_BIT      5
`define PSW_USR0_BIT        6
`define PSW_USR1_BIT        7
`define PSW_BANK_LSB        8
`define PSW_BANK_MSB        9
`define PSW_HOLD_BIT        10
`define PSW_IRQ_GATE_BIT    11
`define PSW_LEVEL_LSB       12
`define PSW_LEVEL_MSB       15
`define PSW_RESET_VALUE     16'h0000
`define PSW_WRITE_MASK      16'hFFDF
`define LEVEL_TOP           4'hF
`define BANK_GLOBAL         2'h0
`define BANK_RESERVED       2'h1
`define BANK_LOCAL1         2'h2
`define BANK_LOCAL2         2'h3
`define WORD_MOST_NEG       16'h8000
`define BYTE_MOST_NEG       8'h80
`define WORD_MAX_POS        16'h7FFF
`define BYTE_MAX_POS        8'h7F
`endif

//--- hdl/alu_status_pkg.sv
// Types shared by the status word block and its helpers.
// Assumes the params header sits on the include path.
`default_nettype none
package alu_status_pkg;
  // Flag class of the operation that completes this cycle.
  typedef enum logic [3:0] {
    OP_NONE    = 4'h0,
    OP_ADD     = 4'h1,
    OP_ADDC    = 4'h2,
    OP_SUB     = 4'h3,
    OP_SUBC    = 4'h4,
    OP_NEG     = 4'h5,
    OP_LOGIC   = 4'h6,
    OP_MULDIV  = 4'h7,
    OP_SHL     = 4'h8,
    OP_SHR     = 4'h9,
    OP_PRIOR   = 4'hA,
    OP_BIT1    = 4'hB,
    OP_BIT2    = 4'hC,
    OP_MOVE    = 4'hD
  } alu_op_t;

  typedef struct packed {
    logic n;
    logic c;
    logic v;
    logic z;
    logic e;
  } flags_t;
endpackage
`default_nettype wire

//--- hdl/flag_calc.sv
// Combinational condition flag evaluation for one ALU operation.
// Assumes operands and result are stable in the cycle done is high.
`include "alu_status_params.svh"
`default_nettype none
module flag_calc
  import alu_status_pkg::*;
(
  // Operation.
  input  wire alu_status_pkg::alu_op_t op,
  input  wire logic                    byte_op,
  input  wire logic                    table_ok,
  // Data.
  input  wire logic [15:0]             src_a,
  input  wire logic [15:0]             src_b,
  input  wire logic [15:0]             result,
  input  wire logic                    carry_out,
  input  wire logic                    shift_last,
  input  wire logic                    shift_sticky,
  input  wire logic                    shift_zero,
  input  wire logic                    muldiv_ovf,
  input  wire logic                    div_by_zero,
  input  wire logic                    bit_a,
  input  wire logic                    bit_b,
  input  wire logic                    z_old,
  // Flags.
  output logic [4:0]                   flags
);
  logic msb;
  logic res_zero;
  logic src_min;
  logic ovf_add;
  logic ovf_sub;
  flags_t f;

  always_comb begin
    msb      = byte_op ? result[7] : result[15];
    res_zero = byte_op ? (result[7:0] == 8'h00) : (result == 16'h0000);
    src_min  = byte_op ? (src_a[7:0] == `BYTE_MOST_NEG) : (src_a == `WORD_MOST_NEG);
    ovf_add  = byte_op ? ((src_a[7] == src_b[7]) && (result[7] != src_a[7]))
                       : ((src_a[15] == src_b[15]) && (result[15] != src_a[15]));
    ovf_sub  = byte_op ? ((src_a[7] != src_b[7]) && (result[7] != src_a[7]))
                       : ((src_a[15] != src_b[15]) && (result[15] != src_a[15]));
    f.n = msb;
    f.c = 1'b0;
    f.v = 1'b0;
    f.z = res_zero;
    f.e = table_ok & src_min;
    unique case (op)
      OP_ADD, OP_ADDC: begin
        f.c = carry_out;
        f.v = ovf_add;
        if (op == OP_ADDC) begin
          f.z = z_old & res_zero;
        end
      end
      OP_SUB, OP_SUBC: begin
        f.c = ~carry_out;
        f.v = ovf_sub;
        if (op == OP_SUBC) begin
          f.z = z_old & res_zero;
        end
      end
      OP_NEG: begin
        f.c = ~carry_out;
        f.v = src_min;
      end
      OP_LOGIC: begin
        f.c = 1'b0;
        f.v = 1'b0;
      end
      OP_MULDIV: begin
        f.c = 1'b0;
        f.v = muldiv_ovf | div_by_zero;
      end
      OP_SHL: begin
        f.c = shift_zero ? 1'b0 : shift_last;
      end
      OP_SHR: begin
        f.c = shift_zero ? 1'b0 : shift_last;
        f.v = shift_zero ? 1'b0 : shift_sticky;
      end
      OP_PRIOR: begin
        f.c = 1'b0;
        f.z = byte_op ? (src_b[7:0] == 8'h00) : (src_b == 16'h0000);
      end
      OP_BIT1: begin
        f.n = bit_a;
        f.z = ~bit_a;
      end
      OP_BIT2: begin
        f.n = bit_a ^ bit_b;
        f.c = bit_a & bit_b;
        f.v = bit_a | bit_b;
        f.z = ~(bit_a | bit_b);
      end
      default: begin
      end
    endcase
    flags = f;
  end
endmodule
`default_nettype wire

//--- hdl/irq_level_gate.sv
// Registered acceptance decision for a pending ordinary or non-maskable interrupt.
// Assumes request level and class come from the interrupt controller on core_clk.
`include "alu_status_params.svh"
`default_nettype none
module irq_level_gate (
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // Request.
  input  wire logic       req_valid,
  input  wire logic [3:0] req_level,
  input  wire logic       req_nmi,
  // State.
  input  wire logic       gate,
  input  wire logic [3:0] level,
  // Decision.
  output logic            accept_q
);
  logic accept_d;

  always_comb begin
    accept_d = req_valid & (req_nmi | (gate & (level != `LEVEL_TOP) & (req_level > level)));
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      accept_q <= 1'b0;
    end else begin
      accept_q <= accept_d;
    end
  end
endmodule
`default_nettype wire

//--- hdl/alu_status_flags.sv
// Processor status word: ALU condition flags, bank select and interrupt status.
// Assumes the pipeline pulses op_done once per completed instruction on core_clk.
//
// How it works
// - An explicit status word write overrides that instruction's implicit flags.
// - A status word read returns the value after the previous instruction.
// - Reset clears N, C, V, Z, E and the multiply-in-progress bit.
// - Sign copies result bit 15 for words, bit 7 for bytes.
// - Bit ops: one operand N=old, C=V=0, Z=not old; two: XOR, AND, OR, NOR.
// - Carry after add; borrow (inverted carry) after subtract or compare.
// - Logical, multiply and divide operations clear carry.
// - Shifts and rotates put last bit out into carry; count zero clears it.
// - Prioritize clears carry and sets zero from the second operand.
// - Add, subtract, negate set overflow when signed range is exceeded.
// - Multiply and divide set overflow if result does not fit; divide by zero sets it.
// - Logical operations clear overflow.
// - Right shifts set overflow as sticky bit of lost bits but the last.
// - Zero flag set when the result is zero.
// - Add or subtract with carry keeps zero only if it was already set.
// - End-of-table set when source is the most negative value, unless unsuited.
// - Multiply-in-progress bit always reads zero; multiply and divide are not interrupted.
// - Bank field selects a register bank; interrupt entry, return and writes update it.
// - Global gate enables interrupts; 4-bit level loaded on entry or by software.
// - At level 15 only traps and non-maskable interrupts are accepted.
// - Reset disables interrupts and sets level zero.
// - Bank code 00 global, 01 reserved, 10 local 1, 11 local 2.
`include "alu_status_params.svh"
`default_nettype none
module alu_status_flags (
  // Clock and reset.
  input  wire logic                    core_clk,
  input  wire logic                    nrst,
  // Completing instruction.
  input  wire logic                    op_done,
  input  wire alu_status_pkg::alu_op_t op,
  input  wire logic                    byte_op,
  input  wire logic                    table_ok,
  input  wire logic                    muldiv_busy,
  // Operand and result data.
  input  wire logic [15:0]             src_a,
  input  wire logic [15:0]             src_b,
  input  wire logic [15:0]             result,
  input  wire logic                    carry_out,
  input  wire logic                    shift_last,
  input  wire logic                    shift_sticky,
  input  wire logic                    shift_zero,
  input  wire logic                    muldiv_ovf,
  input  wire logic                    div_by_zero,
  input  wire logic                    bit_a,
  input  wire logic                    bit_b,
  // Register port.
  input  wire logic                    psw_wr,
  input  wire logic [15:0]             psw_wdata,
  input  wire logic                    psw_rd,
  output logic [15:0]                  psw_rdata,
  // Interrupt entry and return.
  input  wire logic                    isr_entry,
  input  wire logic [3:0]              isr_level,
  input  wire logic [1:0]              isr_bank,
  input  wire logic                    return_from_isr,
  input  wire logic [15:0]             saved_psw,
  input  wire logic                    irq_req,
  input  wire logic [3:0]              irq_req_level,
  input  wire logic                    irq_req_nmi,
  // Status outputs.
  output logic [1:0]                   bank_sel,
  output logic                         bank_reserved,
  output logic                         global_irq_gate,
  output logic [3:0]                   cpu_priority_level,
  output logic                         irq_accept,
  output logic [15:0]                  processor_status_word
);
  import alu_status_pkg::*;

  logic [4:0]  calc_flags;
  logic [4:0]  flags_q;
  logic [4:0]  flags_d;
  logic [1:0]  user_q;
  logic [1:0]  user_d;
  logic [1:0]  bank_q;
  logic [1:0]  bank_d;
  logic        hold_q;
  logic        hold_d;
  logic        gate_q;
  logic        gate_d;
  logic [3:0]  level_q;
  logic [3:0]  level_d;
  logic [15:0] psw_now;
  logic [15:0] rdata_q;
  logic        accept_raw;
  logic        accept_q;
  logic        done_q;
  logic [15:0] word_q;

  // Maps a 16-bit word to the flag field order N, C, V, Z, E.
  function automatic logic [4:0] word_flags(input logic [15:0] w);
    word_flags = {w[`PSW_FLAG_N_BIT], w[`PSW_FLAG_C_BIT], w[`PSW_FLAG_V_BIT],
                  w[`PSW_FLAG_Z_BIT], w[`PSW_FLAG_E_BIT]};
  endfunction

  flag_calc u_calc (
    .op           (op),
    .byte_op      (byte_op),
    .table_ok     (table_ok),
    .src_a        (src_a),
    .src_b        (src_b),
    .result       (result),
    .carry_out    (carry_out),
    .shift_last   (shift_last),
    .shift_sticky (shift_sticky),
    .shift_zero   (shift_zero),
    .muldiv_ovf   (muldiv_ovf),
    .div_by_zero  (div_by_zero),
    .bit_a        (bit_a),
    .bit_b        (bit_b),
    .z_old        (flags_q[1]),
    .flags        (calc_flags)
  );

  irq_level_gate u_gate (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .req_valid (irq_req & ~muldiv_busy),
    .req_level (irq_req_level),
    .req_nmi   (irq_req_nmi),
    .gate      (gate_q),
    .level     (level_q),
    .accept_q  (accept_raw)
  );

  // Assembled word; the multiply-in-progress bit is fixed at zero.
  always_comb begin
    psw_now = {level_q, gate_q, hold_q, bank_q, user_q[1], user_q[0], 1'b0,
               flags_q[0], flags_q[1], flags_q[2], flags_q[3], flags_q[4]};
  end

  // Condition flags: explicit write beats implicit result.
  always_comb begin
    flags_d = flags_q;
    if (psw_wr) begin
      flags_d = word_flags(psw_wdata);
    end else if (return_from_isr) begin
      flags_d = word_flags(saved_psw);
    end else if (op_done && op != OP_NONE) begin
      flags_d = calc_flags;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flags_q <= 5'h00;
    end else begin
      flags_q <= flags_d;
    end
  end

  // General purpose and hold bits.
  always_comb begin
    user_d = user_q;
    hold_d = hold_q;
    if (psw_wr) begin
      user_d = {psw_wdata[`PSW_USR1_BIT], psw_wdata[`PSW_USR0_BIT]};
      hold_d = psw_wdata[`PSW_HOLD_BIT];
    end else if (return_from_isr) begin
      user_d = {saved_psw[`PSW_USR1_BIT], saved_psw[`PSW_USR0_BIT]};
      hold_d = saved_psw[`PSW_HOLD_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      user_q <= 2'h0;
      hold_q <= 1'b0;
    end else begin
      user_q <= user_d;
      hold_q <= hold_d;
    end
  end

  // Bank select.
  always_comb begin
    bank_d = bank_q;
    if (psw_wr) begin
      bank_d = psw_wdata[`PSW_BANK_MSB:`PSW_BANK_LSB];
    end else if (return_from_isr) begin
      bank_d = saved_psw[`PSW_BANK_MSB:`PSW_BANK_LSB];
    end else if (isr_entry) begin
      bank_d = isr_bank;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bank_q <= `BANK_GLOBAL;
    end else begin
      bank_q <= bank_d;
    end
  end

  // Interrupt gate and priority level.
  always_comb begin
    gate_d  = gate_q;
    level_d = level_q;
    if (psw_wr) begin
      gate_d  = psw_wdata[`PSW_IRQ_GATE_BIT];
      level_d = psw_wdata[`PSW_LEVEL_MSB:`PSW_LEVEL_LSB];
    end else if (return_from_isr) begin
      gate_d  = saved_psw[`PSW_IRQ_GATE_BIT];
      level_d = saved_psw[`PSW_LEVEL_MSB:`PSW_LEVEL_LSB];
    end else if (isr_entry) begin
      level_d = isr_level;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      gate_q  <= 1'b0;
      level_q <= 4'h0;
    end else begin
      gate_q  <= gate_d;
      level_q <= level_d;
    end
  end

  // Read returns the stored word, which holds the previous instruction's outcome.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= `PSW_RESET_VALUE;
    end else if (psw_rd) begin
      rdata_q <= psw_now;
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  // Ordinary acceptance is dropped if the gate closed or the level reached 15 meanwhile.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      accept_q <= 1'b0;
    end else begin
      accept_q <= accept_raw & (irq_req_nmi | (gate_q & (level_q != `LEVEL_TOP)));
    end
  end

  // Registered copies of the status word and its fields.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      word_q <= `PSW_RESET_VALUE;
      done_q <= 1'b0;
    end else begin
      word_q <= {level_d, gate_d, hold_d, bank_d, user_d, 1'b0,
                 flags_d[0], flags_d[1], flags_d[2], flags_d[3], flags_d[4]};
      done_q <= (bank_d == `BANK_RESERVED);
    end
  end

  assign psw_rdata             = rdata_q;
  assign bank_sel              = word_q[`PSW_BANK_MSB:`PSW_BANK_LSB];
  assign bank_reserved         = done_q;
  assign global_irq_gate       = word_q[`PSW_IRQ_GATE_BIT];
  assign cpu_priority_level    = word_q[`PSW_LEVEL_MSB:`PSW_LEVEL_LSB];
  assign irq_accept            = accept_q;
  assign processor_status_word = word_q;
endmodule
`default_nettype wire

//--- tb/irq_source_model.sv
// Interrupt controller and entry sequencer that faces the status word block.
// Assumes the bench holds raise and the wanted level, class and bank while a request is open.
`default_nettype none
module irq_source_model (
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // Bench control.
  input  wire logic       raise,
  input  wire logic [3:0] want_level,
  input  wire logic       want_nmi,
  input  wire logic [1:0] want_bank,
  // Block side.
  input  wire logic       irq_accept,
  output logic            irq_req,
  output logic [3:0]      irq_req_level,
  output logic            irq_req_nmi,
  output logic            isr_entry,
  output logic [3:0]      isr_level,
  output logic [1:0]      isr_bank
);
  timeunit 1ns;
  timeprecision 1ns;
  logic taken_q;

  // Level and bank qualifiers show the inverse while they carry no meaning; the class passes straight through.
  assign irq_req       = raise && !taken_q;
  assign irq_req_level = irq_req ? want_level : ~want_level;
  assign irq_req_nmi   = want_nmi;
  assign isr_level     = isr_entry ? want_level : ~want_level;
  assign isr_bank      = isr_entry ? want_bank : ~want_bank;

  // One entry pulse per accepted request; later accepts are ignored.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      taken_q   <= 1'b0;
      isr_entry <= 1'b0;
    end else begin
      isr_entry <= irq_accept && !taken_q && raise;
      taken_q   <= raise && (taken_q || irq_accept);
    end
  end
endmodule
`default_nettype wire

//--- tb/alu_status_checker.sv
// Port assertions for the status word block.
// Assumes it is bound to the block and shares its single clock.
`include "alu_status_params.svh"
`default_nettype none
module alu_status_checker (
  // Clock and reset.
  input wire logic                    core_clk,
  input wire logic                    nrst,
  // Instruction.
  input wire logic                    op_done,
  input wire alu_status_pkg::alu_op_t op,
  input wire logic                    byte_op,
  input wire logic [15:0]             result,
  input wire logic                    muldiv_busy,
  // Register port.
  input wire logic                    psw_wr,
  input wire logic [15:0]             psw_wdata,
  input wire logic                    psw_rd,
  input wire logic [15:0]             psw_rdata,
  // Interrupts.
  input wire logic                    isr_entry,
  input wire logic [3:0]              isr_level,
  input wire logic [1:0]              isr_bank,
  input wire logic                    return_from_isr,
  input wire logic [15:0]             saved_psw,
  input wire logic                    irq_req,
  input wire logic                    irq_req_nmi,
  input wire logic                    irq_accept,
  // Status.
  input wire logic [1:0]              bank_sel,
  input wire logic                    bank_reserved,
  input wire logic                    global_irq_gate,
  input wire logic [3:0]              cpu_priority_level,
  input wire logic [15:0]             processor_status_word
);
  timeunit 1ns;
  timeprecision 1ns;
  import alu_status_pkg::*;
  logic plain;
  logic msb;
  assign plain = !psw_wr && !return_from_isr;
  assign msb   = byte_op ? result[7] : result[15];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  reset_clear_a: assert property ($rose(nrst) |-> processor_status_word == 16'h0000)
    else $error("status word not clear after reset");
  muldiv_zero_a: assert property (psw_wr |=> processor_status_word[`PSW_MULDIV_BIT] == 1'b0)
    else $error("multiply bit not zero");
  write_wins_a: assert property (psw_wr |=> processor_status_word == ($past(psw_wdata) & `PSW_WRITE_MASK))
    else $error("written word not taken");
  read_old_a: assert property (psw_rd |=> psw_rdata == $past(processor_status_word))
    else $error("read data differs from prior word");
  sign_msb_a: assert property (plain && op_done && op inside {OP_ADD, OP_SUB, OP_MOVE}
    |=> processor_status_word[`PSW_FLAG_N_BIT] == $past(msb)) else $error("sign flag wrong");
  logic_clear_a: assert property (plain && op_done && op == OP_LOGIC
    |=> processor_status_word[2:1] == 2'h0) else $error("logic op left carry or overflow");
  entry_load_a: assert property (isr_entry && plain
    |=> cpu_priority_level == $past(isr_level) && bank_sel == $past(isr_bank)) else $error("entry not loaded");
  return_load_a: assert property (return_from_isr && !psw_wr
    |=> processor_status_word == ($past(saved_psw) & `PSW_WRITE_MASK)) else $error("return not restored");
  top_level_a: assert property ((irq_req && !irq_req_nmi && cpu_priority_level == `LEVEL_TOP)[*2]
    |=> !irq_accept) else $error("accepted at top level");
  nmi_take_a: assert property (irq_req && irq_req_nmi |-> ##2 irq_accept)
    else $error("non-maskable request not accepted");
  busy_block_a: assert property ((irq_req && muldiv_busy && !irq_req_nmi)[*2] |=> !irq_accept)
    else $error("accepted during multiply");
  word_view_a: assert property (bank_reserved == (bank_sel == `BANK_RESERVED)
    && processor_status_word[15:11] == {cpu_priority_level, global_irq_gate}
    && processor_status_word[9:8] == bank_sel) else $error("status outputs disagree with word");
endmodule
`default_nettype wire

//--- tb/test_alu_status_flags.sv
// Self-checking bench for the status word block.
// Assumes the design package and params header are compiled first.
`default_nettype none
module test_alu_status_flags;
  timeunit 1ns;
  timeprecision 1ns;
  import alu_status_pkg::*;
  logic core_clk = 1'b0, nrst = 1'b0, op_done = 1'b0, byte_op = 1'b0, table_ok = 1'b1, muldiv_busy = 1'b0;
  logic carry_out = 1'b0, shift_last = 1'b0, shift_sticky = 1'b0, shift_zero = 1'b0, muldiv_ovf = 1'b0;
  logic div_by_zero = 1'b0, bit_a = 1'b0, bit_b = 1'b0, psw_wr = 1'b0, psw_rd = 1'b0, return_from_isr = 1'b0;
  logic raise = 1'b0, want_nmi = 1'b0;
  logic [1:0] want_bank = 2'h2;
  logic [3:0] want_level = 4'h5;
  logic [15:0] src_a = 16'h0000, src_b = 16'h0000, result = 16'h0000, psw_wdata = 16'h0000, saved_psw = 16'h0000;
  alu_op_t op = OP_NONE;
  logic irq_req, irq_req_nmi, isr_entry, bank_reserved, global_irq_gate, irq_accept;
  logic [1:0] isr_bank, bank_sel;
  logic [3:0] irq_req_level, isr_level, cpu_priority_level;
  logic [15:0] psw_rdata, processor_status_word;
  int num_errors = 0;
  int cmp_count = 0;

  always #50 core_clk = ~core_clk;

  alu_status_flags dut (.core_clk, .nrst, .op_done, .op, .byte_op, .table_ok, .muldiv_busy, .src_a, .src_b,
    .result, .carry_out, .shift_last, .shift_sticky, .shift_zero, .muldiv_ovf, .div_by_zero, .bit_a, .bit_b,
    .psw_wr, .psw_wdata, .psw_rd, .psw_rdata, .isr_entry, .isr_level, .isr_bank, .return_from_isr, .saved_psw,
    .irq_req, .irq_req_level, .irq_req_nmi, .bank_sel, .bank_reserved, .global_irq_gate, .cpu_priority_level,
    .irq_accept, .processor_status_word);
  irq_source_model far (.core_clk, .nrst, .raise, .want_level, .want_nmi, .want_bank, .irq_accept, .irq_req,
    .irq_req_level, .irq_req_nmi, .isr_entry, .isr_level, .isr_bank);

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Each task starts and ends just after a rising edge.
  task automatic run(input alu_op_t o, input logic b, input logic [15:0] a, input logic [15:0] r,
                     input logic co, input logic [4:0] e, input logic [4:0] m = 5'h1F);
    op_done <= 1'b1;
    op <= o;
    byte_op <= b;
    src_a <= a;
    result <= r;
    carry_out <= co;
    @(posedge core_clk);
    op_done <= 1'b0;
    @(negedge core_clk);
    chk({11'h0, processor_status_word[4:0] & m}, {11'h0, e & m});
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [15:0] d);
    psw_wr <= 1'b1;
    psw_wdata <= d;
    @(posedge core_clk);
    psw_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [15:0] exp);
    psw_rd <= 1'b1;
    @(posedge core_clk);
    psw_rd <= 1'b0;
    @(negedge core_clk);
    chk(psw_rdata, exp);
    @(posedge core_clk);
  endtask

  // Opens a request, lets it run its course, then checks level and bank.
  task automatic irq(input logic [3:0] l, input logic n, input logic [5:0] exp);
    want_level <= l;
    want_nmi <= n;
    raise <= 1'b1;
    repeat (8) @(posedge core_clk);
    raise <= 1'b0;
    @(negedge core_clk);
    chk({10'h0, cpu_priority_level, bank_sel}, {10'h0, exp});
    @(posedge core_clk);
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    @(negedge core_clk);
    chk(processor_status_word, 16'h0000);
    chk({7'h0, bank_sel, bank_reserved, global_irq_gate, cpu_priority_level, irq_accept}, 16'h0000);
    @(posedge core_clk);
    src_b <= 16'h0001;
    run(OP_ADD, 1'b0, 16'h7FFF, 16'h8000, 1'b0, 5'b00101);
    src_b <= 16'h0000;
    run(OP_ADDC, 1'b0, 16'h0000, 16'h0000, 1'b0, 5'b00000);
    src_b <= 16'h0080;
    run(OP_ADD, 1'b1, 16'h0080, 16'h0100, 1'b1, 5'b11110);
    src_b <= 16'h0000;
    run(OP_ADDC, 1'b0, 16'h0000, 16'h0000, 1'b0, 5'b01000);
    run(OP_SUBC, 1'b0, 16'h0000, 16'h0000, 1'b1, 5'b01000);
    src_b <= 16'h0007;
    run(OP_SUB, 1'b0, 16'h0005, 16'hFFFE, 1'b0, 5'b00011);
    src_b <= 16'h0001;
    run(OP_SUB, 1'b0, 16'h8000, 16'h7FFF, 1'b1, 5'b10100);
    run(OP_NEG, 1'b0, 16'h8000, 16'h8000, 1'b1, 5'b10101);
    table_ok <= 1'b0;
    run(OP_LOGIC, 1'b0, 16'h8000, 16'h0000, 1'b1, 5'b01000);
    muldiv_ovf <= 1'b1;
    run(OP_MULDIV, 1'b0, 16'h0000, 16'h1234, 1'b1, 5'b00100);
    muldiv_ovf <= 1'b0;
    div_by_zero <= 1'b1;
    run(OP_MULDIV, 1'b0, 16'h0000, 16'h1234, 1'b1, 5'b00100);
    div_by_zero <= 1'b0;
    shift_last <= 1'b1;
    shift_sticky <= 1'b1;
    run(OP_SHR, 1'b0, 16'h0000, 16'h0001, 1'b0, 5'b00110);
    shift_sticky <= 1'b0;
    shift_zero <= 1'b1;
    run(OP_SHR, 1'b0, 16'h0000, 16'h0000, 1'b0, 5'b01000);
    shift_zero <= 1'b0;
    run(OP_SHL, 1'b0, 16'h0000, 16'h8000, 1'b0, 5'b00011, 5'b01011);
    src_b <= 16'h0005;
    run(OP_PRIOR, 1'b0, 16'h0000, 16'h0000, 1'b1, 5'b00000, 5'b11011);
    bit_a <= 1'b1;
    run(OP_BIT1, 1'b0, 16'h0000, 16'h0000, 1'b1, 5'b00001, 5'b01111);
    run(OP_BIT2, 1'b0, 16'h0000, 16'h0000, 1'b1, 5'b00101, 5'b01111);
    bit_a <= 1'b0;
    run(OP_BIT2, 1'b0, 16'h0000, 16'h0000, 1'b1, 5'b01000, 5'b01111);
    table_ok <= 1'b1;
    run(OP_MOVE, 1'b1, 16'h0080, 16'h0080, 1'b0, 5'b10001);
    run(OP_NONE, 1'b0, 16'h8000, 16'h0000, 1'b1, 5'b10001);
    rd(16'h0011);
    psw_wr <= 1'b1;
    psw_wdata <= 16'hFFFF;
    op_done <= 1'b1;
    op <= OP_ADD;
    @(posedge core_clk);
    psw_wr <= 1'b0;
    op_done <= 1'b0;
    rd(16'hFFDF);
    psw_wr <= 1'b1;
    psw_wdata <= 16'h3C6A;
    @(posedge core_clk);
    psw_wr <= 1'b0;
    psw_rd <= 1'b1;
    @(posedge core_clk);
    psw_rd <= 1'b0;
    @(negedge core_clk);
    chk(psw_rdata, 16'h3C4A);
    chk(processor_status_word, 16'h3C4A);
    @(posedge core_clk);
    for (int b = 0; b < 4; b++) begin
      wr({6'h00, b[1:0], 8'h00});
      chk({13'h0, bank_sel, bank_reserved}, {13'h0, b[1:0], b == 1});
    end
    wr(16'h3800);
    irq(4'h5, 1'b0, 6'h16);
    return_from_isr <= 1'b1;
    saved_psw <= 16'h3800;
    @(posedge core_clk);
    return_from_isr <= 1'b0;
    @(negedge core_clk);
    chk(processor_status_word, 16'h3800);
    @(posedge core_clk);
    wr(16'hF800);
    irq(4'h7, 1'b0, 6'h3C);
    irq(4'h7, 1'b1, 6'h1E);
    wr(16'h0800);
    muldiv_busy <= 1'b1;
    irq(4'h7, 1'b0, 6'h00);
    muldiv_busy <= 1'b0;
    irq(4'h7, 1'b0, 6'h1E);
    wr(16'h0000);
    irq(4'h7, 1'b0, 6'h00);
    wr(16'hFFFF);
    nrst <= 1'b0;
    @(posedge core_clk);
    nrst <= 1'b1;
    @(negedge core_clk);
    chk(processor_status_word, 16'h0000);
    summarize();
  end

  initial begin
    repeat (3000) @(posedge core_clk);
    num_errors++;
    $display("mismatch at %0t: run did not finish", $time);
    summarize();
  end
endmodule

bind alu_status_flags alu_status_checker u_check (.core_clk, .nrst, .op_done, .op, .byte_op, .result,
  .muldiv_busy, .psw_wr, .psw_wdata, .psw_rd, .psw_rdata, .isr_entry, .isr_level, .isr_bank, .return_from_isr,
  .saved_psw, .irq_req, .irq_req_nmi, .irq_accept, .bank_sel, .bank_reserved, .global_irq_gate,
  .cpu_priority_level, .processor_status_word);
`default_nettype wire
